// ==== sct_timer.sv ====
// Top of the 16-bit capture timer with its AXI4-Lite register slave.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module sct_timer
	import sct_pkg::*;
#(
	parameter int RADIO_EVENTS = 8
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [CHAN_COUNT-1:0] capture_pin_in,
	output logic [CHAN_COUNT-1:0] capture_pin_out,
	output logic [CHAN_COUNT-1:0] capture_pin_oe,
	input wire logic [RADIO_EVENTS-1:0] radio_event,
	output logic timer_irq
);
	logic [15:0] count;
	logic count_down;
	logic [1:0] count_mode_field;
	logic [1:0] prescale_select;
	logic overflow_flag;
	logic [CHAN_COUNT-1:0] chan_event_flag;
	logic [15:0] terminal_value;
	logic [7:0] terminal_low_buf;
	logic [7:0] count_high_byte;
	logic [2:0] tick_speed_field;
	logic [2:0] sys_clock_speed_field;
	logic overflow_mask;
	logic timer_irq_enable;
	logic [RADIO_EVENTS-1:0] radio_irq_mask;
	logic [4:0] chan_control_reg [CHAN_COUNT];
	logic [15:0] chan_capture [CHAN_COUNT];
	logic [CHAN_COUNT-1:0] pin_meta;
	logic [CHAN_COUNT-1:0] pin_sync;
	logic [CHAN_COUNT-1:0] pin_prev;
	logic [CHAN_COUNT-1:0] capture_hit;
	logic active_edge;
	logic overflow_event;
	logic cpu_timer_flag;
	logic [7:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	logic do_write;
	logic do_read;
	logic [31:0] read_value;
	logic read_ok;
	logic wr_count_low;
	logic wr_control;
	logic rd_count_low;

	function automatic logic chan_hit(input logic [7:0] addr, input logic [7:0] base,
		input int idx);
		chan_hit = (addr == 8'(base + 8'(idx * CHAN_STEP)));
	endfunction

	sct_tick_gen u_tick
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_speed_field(tick_speed_field),
		.prescale_select(prescale_select),
		.active_edge(active_edge)
	);

	// Write address and data are held until both are present, in either order.
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		else if (do_write)
			aw_held <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		else if (do_write)
			w_held <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr <= REG_CAPT0 + 8'(2 * CHAN_STEP) &&
				aw_addr[1:0] == 2'h0) ? AXI_OKAY : AXI_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Only byte lane 0 carries register contents; other lanes are ignored.
	assign wr_control = do_write && w_strb[0] && aw_addr == REG_CONTROL;
	assign wr_count_low = do_write && w_strb[0] && aw_addr == REG_COUNT_LOW;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_mode_field <= MODE_STOP;
			prescale_select <= '0;
			terminal_low_buf <= '0;
			terminal_value <= COUNT_FULL;
			tick_speed_field <= '0;
			sys_clock_speed_field <= '0;
			overflow_mask <= 1'b0;
			timer_irq_enable <= 1'b0;
			radio_irq_mask <= '0;
			for (int i = 0; i < CHAN_COUNT; i++)
				chan_control_reg[i] <= '0;
		end
		else if (do_write && w_strb[0])
		begin
			if (aw_addr == REG_CONTROL)
			begin
				count_mode_field <= w_data[CTL_MODE_LSB +: 2];
				prescale_select <= w_data[CTL_DIV_LSB +: 2];
			end
			if (aw_addr == REG_TERM_LOW)
				terminal_low_buf <= w_data[7:0];
			// Low byte is buffered so that a half-written terminal value never takes effect.
			if (aw_addr == REG_TERM_HIGH)
				terminal_value <= {w_data[7:0], terminal_low_buf};
			if (aw_addr == REG_CLOCK_CTRL)
			begin
				tick_speed_field <= w_data[CLK_TICK_LSB +: 3];
				sys_clock_speed_field <= w_data[CLK_SYS_LSB +: 3];
			end
			if (aw_addr == REG_IRQ_CTRL)
			begin
				overflow_mask <= w_data[IRQ_OVFMASK_BIT];
				timer_irq_enable <= w_data[IRQ_ENABLE_BIT];
			end
			if (aw_addr == REG_RADIO_MASK)
				radio_irq_mask <= w_data[RADIO_EVENTS-1:0];
			for (int i = 0; i < CHAN_COUNT; i++)
				if (chan_hit(aw_addr, REG_CHAN_CTRL0, i))
					chan_control_reg[i] <= w_data[4:0];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count <= COUNT_ZERO;
			count_down <= 1'b0;
		end
		else if (wr_count_low)
		begin
			count <= COUNT_ZERO;
			count_down <= 1'b0;
		end
		else if (active_edge)
		begin
			unique case (count_mode_field)
				MODE_STOP: count <= count;
				MODE_FREE: count <= count + COUNT_ONE;
				MODE_MODULO: count <= (count >= terminal_value) ? COUNT_ZERO
					: count + COUNT_ONE;
				MODE_UPDOWN:
				begin
					if (!count_down && count >= terminal_value)
					begin
						count <= (count == COUNT_ZERO) ? COUNT_ZERO : count - COUNT_ONE;
						count_down <= (count != COUNT_ZERO);
					end
					else if (count_down && count == COUNT_ONE)
					begin
						count <= COUNT_ZERO;
						count_down <= 1'b0;
					end
					else if (count_down)
						count <= count - COUNT_ONE;
					else
						count <= count + COUNT_ONE;
				end
			endcase
		end
	end

	// overflow at COUNT_FULL (free), at terminal value (modulo), at zero (up/down)
	// The flag is raised on the edge where the counter arrives at the value.
	always_comb
	begin
		overflow_event = 1'b0;
		if (active_edge && !wr_count_low)
		begin
			unique case (count_mode_field)
				MODE_STOP: overflow_event = 1'b0;
				MODE_FREE: overflow_event = (count + COUNT_ONE == COUNT_FULL);
				MODE_MODULO: overflow_event = (count < terminal_value) &&
					(count + COUNT_ONE == terminal_value);
				MODE_UPDOWN: overflow_event = count_down && (count == COUNT_ONE);
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_meta <= '0;
			pin_sync <= '0;
			pin_prev <= '0;
		end
		else
		begin
			pin_meta <= capture_pin_in;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// one pin per channel
	// Capture pins are inputs only here; compare outputs are not built.
	assign capture_pin_out = '0;
	assign capture_pin_oe = '0;

	generate
		for (genvar c = 0; c < CHAN_COUNT; c++)
		begin : g_chan
			logic rise;
			logic fall;
			logic pin_edge;
			assign rise = pin_sync[c] && !pin_prev[c];
			assign fall = !pin_sync[c] && pin_prev[c];
			assign pin_edge = (chan_control_reg[c][CCTL_EDGE_LSB] && rise) ||
				(chan_control_reg[c][CCTL_EDGE_LSB + 1] && fall);
			assign capture_hit[c] = chan_control_reg[c][CCTL_CAPT_BIT] &&
				(count_mode_field != MODE_STOP) &&
				(chan_control_reg[c][CCTL_SRC_BIT] ? |(radio_event & radio_irq_mask)
				: pin_edge);

			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					chan_capture[c] <= COUNT_ZERO;
				else if (capture_hit[c])
					chan_capture[c] <= count;
			end
		end
	endgenerate

	// flags clear on reset
	// Software clears a flag by writing zero to it; a same-cycle event wins.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			overflow_flag <= 1'b0;
			chan_event_flag <= '0;
		end
		else
		begin
			overflow_flag <= overflow_event ||
				(overflow_flag && !(wr_control && !w_data[CTL_OVF_BIT]));
			for (int i = 0; i < CHAN_COUNT; i++)
				chan_event_flag[i] <= capture_hit[i] || (chan_event_flag[i] &&
					!(wr_control && !w_data[CTL_FLAG_LSB + i]));
		end
	end

	always_comb
	begin
		cpu_timer_flag = overflow_flag && overflow_mask;
		for (int i = 0; i < CHAN_COUNT; i++)
			cpu_timer_flag = cpu_timer_flag ||
				(chan_event_flag[i] && chan_control_reg[i][CCTL_MASK_BIT]);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			timer_irq <= 1'b0;
		else
			timer_irq <= cpu_timer_flag && timer_irq_enable;
	end

	// Read side.
	assign s_axi_arready = !s_axi_rvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign rd_count_low = do_read && s_axi_araddr == REG_COUNT_LOW;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_high_byte <= '0;
		else if (rd_count_low)
			count_high_byte <= count[15:8];
	end

	always_comb
	begin
		read_value = '0;
		read_ok = 1'b1;
		unique case (s_axi_araddr)
			REG_CONTROL: read_value[7:0] = {overflow_flag, chan_event_flag,
				prescale_select, count_mode_field};
			REG_COUNT_LOW: read_value[7:0] = count[7:0];
			REG_COUNT_HIGH: read_value[7:0] = count_high_byte;
			REG_TERM_LOW: read_value[7:0] = terminal_value[7:0];
			REG_TERM_HIGH: read_value[7:0] = terminal_value[15:8];
			REG_CLOCK_CTRL: read_value[5:0] = {sys_clock_speed_field, tick_speed_field};
			REG_IRQ_CTRL: read_value[2:0] = {cpu_timer_flag, timer_irq_enable,
				overflow_mask};
			REG_RADIO_MASK: read_value[RADIO_EVENTS-1:0] = radio_irq_mask;
			default:
			begin
				read_ok = 1'b0;
				for (int i = 0; i < CHAN_COUNT; i++)
				begin
					if (chan_hit(s_axi_araddr, REG_CHAN_CTRL0, i))
					begin
						read_value[4:0] = chan_control_reg[i];
						read_ok = 1'b1;
					end
					if (chan_hit(s_axi_araddr, REG_CAPT0, i))
					begin
						read_value[15:0] = chan_capture[i];
						read_ok = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= AXI_OKAY;
		end
		else if (do_read)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_value;
			s_axi_rresp <= read_ok ? AXI_OKAY : AXI_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule

// ==== sct_pkg.sv ====
// Package with register map, field layout and constants of the capture timer.
package sct_pkg;
	localparam logic [7:0] REG_CONTROL = 8'h00;
	localparam logic [7:0] REG_COUNT_LOW = 8'h04;
	localparam logic [7:0] REG_COUNT_HIGH = 8'h08;
	localparam logic [7:0] REG_TERM_LOW = 8'h0C;
	localparam logic [7:0] REG_TERM_HIGH = 8'h10;
	localparam logic [7:0] REG_CLOCK_CTRL = 8'h14;
	localparam logic [7:0] REG_IRQ_CTRL = 8'h18;
	localparam logic [7:0] REG_RADIO_MASK = 8'h1C;
	localparam logic [7:0] REG_CHAN_CTRL0 = 8'h20;
	localparam logic [7:0] REG_CAPT0 = 8'h30;
	localparam int CHAN_COUNT = 3;
	localparam int CHAN_STEP = 4;
	localparam logic [1:0] MODE_STOP = 2'h0;
	localparam logic [1:0] MODE_FREE = 2'h1;
	localparam logic [1:0] MODE_MODULO = 2'h2;
	localparam logic [1:0] MODE_UPDOWN = 2'h3;
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_DIV_LSB = 2;
	localparam int CTL_FLAG_LSB = 4;
	localparam int CTL_OVF_BIT = 7;
	localparam int CCTL_EDGE_LSB = 0;
	localparam int CCTL_MASK_BIT = 2;
	localparam int CCTL_SRC_BIT = 3;
	localparam int CCTL_CAPT_BIT = 4;
	localparam int CLK_TICK_LSB = 0;
	localparam int CLK_SYS_LSB = 3;
	localparam int IRQ_OVFMASK_BIT = 0;
	localparam int IRQ_ENABLE_BIT = 1;
	localparam int IRQ_CPUFLAG_BIT = 2;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_FULL = 16'hFFFF;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [6:0] DIV_RATIO_8 = 7'h07;
	localparam logic [6:0] DIV_RATIO_32 = 7'h1F;
	localparam logic [6:0] DIV_RATIO_128 = 7'h7F;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ==== sct_tick_gen.sv ====
// Timer tick generator: tick speed divider followed by the counting prescaler.
`timescale 1ns/1ps
module sct_tick_gen
	import sct_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] tick_speed_field,
	input wire logic [1:0] prescale_select,
	output logic active_edge
);
	logic [6:0] tick_cnt;
	logic [6:0] tick_limit;
	logic tick;
	logic [6:0] pre_cnt;
	logic [6:0] pre_limit;

	// tick rate from speed field
	// The system clock itself is never touched; only a tick enable is derived.
	assign tick_limit = 7'((8'h01 << tick_speed_field) - 8'h01);
	assign tick = (tick_cnt >= tick_limit);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tick_cnt <= '0;
		else if (tick)
			tick_cnt <= '0;
		else
			tick_cnt <= tick_cnt + 7'h01;
	end

	always_comb
	begin
		unique case (prescale_select)
			2'h0: pre_limit = '0;
			2'h1: pre_limit = DIV_RATIO_8;
			2'h2: pre_limit = DIV_RATIO_32;
			2'h3: pre_limit = DIV_RATIO_128;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pre_cnt <= '0;
		else if (tick)
			pre_cnt <= (pre_cnt >= pre_limit) ? 7'h00 : pre_cnt + 7'h01;
	end

	assign active_edge = tick && (pre_cnt >= pre_limit);
endmodule

// ==== sct_pin_src.sv ====
// Model of the external sources that drive the three capture pins.
`timescale 1ns/1ps
module sct_pin_src
(
	input wire logic aclk,
	input wire logic [2:0] pin_want,
	output logic [2:0] capture_pin_in
);
	logic hold = 1'b0;
	initial capture_pin_in = 3'b010;
	// pulse width
	// A new level is taken every second clock, so the synchroniser always sees each pulse.
	always @(posedge aclk)
	begin
		hold <= !hold;
		if (hold)
			capture_pin_in <= pin_want;
	end
endmodule

// ==== sct_timer_asserts.sv ====
// Checker of the capture timer's behaviour at its ports.
`timescale 1ns/1ps
module sct_timer_asserts
	import sct_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [CHAN_COUNT-1:0] capture_pin_out,
	input wire logic [CHAN_COUNT-1:0] capture_pin_oe,
	input wire logic timer_irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	pin_input_a: assert property (capture_pin_oe == '0 && capture_pin_out == '0)
		else $error("capture pin driven");
	reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=>
		!timer_irq && !s_axi_bvalid && !s_axi_rvalid) else $error("busy in reset");
	write_answer_a: assert property (wr_taken |=> ##1 s_axi_bvalid)
		else $error("no write response");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read response");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	resp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	write_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	read_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	cover property (wr_taken);
	cover property ($rose(timer_irq));
	cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind sct_timer sct_timer_asserts u_chk
(
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .capture_pin_out, .capture_pin_oe, .timer_irq
);

// ==== tb_top.sv ====
// Self-checking bench of the capture timer with a counting model.
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin error_cnt++; \
	$display("ERROR %s exp %0h got %0h", n, e, s); end end
module tb_top
	import sct_pkg::*;
();
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [2:0] s_axi_awprot = 3'h0;
	logic [2:0] s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_bready = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, d, c0, c1;
	logic [2:0] capture_pin_in, capture_pin_out, capture_pin_oe;
	logic [2:0] pin_want = 3'b010;
	logic [7:0] radio_event = 8'h00;
	int error_cnt = 0;
	int tests_run = 0;
	int ratio[4] = '{1, 8, 32, 128};
	int t, n, tol;
	always #25 aclk = !aclk;
	sct_timer dut
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.capture_pin_in, .capture_pin_out, .capture_pin_oe, .radio_event, .timer_irq
	);
	sct_pin_src src (.aclk, .pin_want, .capture_pin_in);
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		bit ad;
		bit dd;
		ad = 0;
		dd = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ad && dd))
		begin
			@(posedge aclk);
			ad |= s_axi_awready;
			dd |= s_axi_wready;
			s_axi_awvalid <= !ad;
			s_axi_wvalid <= !dd;
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b0;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		repeat ($urandom_range(2, 0)) @(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		rs = s_axi_rresp;
	endtask
	task automatic rdcnt(output logic [31:0] c);
		logic [31:0] h;
		rd(REG_COUNT_LOW, c, r);
		rd(REG_COUNT_HIGH, h, r);
		c = {16'h0, h[7:0], c[7:0]};
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (100000) @(posedge aclk);
		error_cnt++;
		print_verdict();
	end
	initial
	begin
		void'($urandom(51335));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(REG_CONTROL, d, r);
		`CHK("control", 32'h0, d)
		rdcnt(c0);
		`CHK("reset count", 32'h0, c0)
		rd(8'h40, d, r);
		`CHK("unmapped read", AXI_SLVERR, r)
		wr(8'h40, 32'h1, r);
		`CHK("unmapped write", AXI_SLVERR, r)
		for (int k = 0; k < 4; k++)
		begin
			t = $urandom_range(2, 0);
			n = $urandom_range(1200, 800);
			tol = 6 / (ratio[k] << t) + 1;
			wr(REG_CLOCK_CTRL, 32'(t), r);
			wr(REG_COUNT_LOW, 32'h5A, r);
			wr(REG_CONTROL, 32'(k << CTL_DIV_LSB) | 32'(MODE_FREE), r);
			repeat (n) @(posedge aclk);
			wr(REG_CONTROL, 32'h0, r);
			rdcnt(c0);
			d = (n + 3) / (ratio[k] << t);
			`CHK("count rate", 1'b1, c0 + tol >= d && c0 <= d + tol)
			rd(REG_COUNT_LOW, c1, r);
			`CHK("held count", c0[7:0], c1[7:0])
			wr(REG_COUNT_LOW, 32'h0, r);
			rd(REG_COUNT_HIGH, d, r);
			`CHK("latched high", c0[15:8], d[7:0])
			rdcnt(c1);
			`CHK("cleared count", 32'h0, c1)
		end
		wr(REG_CLOCK_CTRL, 32'h0, r);
		wr(REG_COUNT_LOW, 32'h0, r);
		wr(REG_CONTROL, 32'(MODE_FREE), r);
		repeat (65536) @(posedge aclk);
		wr(REG_CONTROL, 32'h80, r);
		rd(REG_CONTROL, d, r);
		`CHK("free overflow", 1'b1, d[CTL_OVF_BIT])
		rdcnt(c0);
		`CHK("free wrap", 1'b1, c0 < 16)
		for (int m = 2; m < 4; m++)
		begin
			t = $urandom_range(40, 5);
			wr(REG_TERM_LOW, 32'(t), r);
			wr(REG_TERM_HIGH, 32'h0, r);
			wr(REG_COUNT_LOW, 32'h0, r);
			wr(REG_CONTROL, 32'(m), r);
			repeat ($urandom_range(300, 200)) @(posedge aclk);
			wr(REG_CONTROL, 32'h80, r);
			rd(REG_CONTROL, d, r);
			`CHK("overflow", 1'b1, d[CTL_OVF_BIT])
			rdcnt(c0);
			`CHK("count bound", 1'b1, c0 <= t)
		end
		wr(REG_IRQ_CTRL, 32'h1, r);
		`CHK("write okay", AXI_OKAY, r)
		repeat (3) @(posedge aclk);
		`CHK("irq gated", 1'b0, timer_irq)
		rd(REG_IRQ_CTRL, d, r);
		`CHK("cpu flag", 1'b1, d[IRQ_CPUFLAG_BIT])
		`CHK("read okay", AXI_OKAY, r)
		wr(REG_IRQ_CTRL, 32'h3, r);
		repeat (3) @(posedge aclk);
		`CHK("irq on", 1'b1, timer_irq)
		wr(REG_CONTROL, 32'h0, r);
		repeat (3) @(posedge aclk);
		`CHK("irq cleared", 1'b0, timer_irq)
		wr(REG_CLOCK_CTRL, 32'h0, r);
		wr(REG_RADIO_MASK, 32'h1, r);
		wr(REG_CHAN_CTRL0, 32'h15, r);
		wr(REG_CHAN_CTRL0 + 8'h04, 32'h16, r);
		wr(REG_CHAN_CTRL0 + 8'h08, 32'h1D, r);
		wr(REG_CONTROL, 32'h0D, r);
		repeat (300) @(posedge aclk);
		rdcnt(c0);
		pin_want <= 3'b101;
		repeat (20) @(posedge aclk);
		rdcnt(c1);
		for (int k = 0; k < 2; k++)
		begin
			rd(REG_CAPT0 + 8'(CHAN_STEP * k), d, r);
			`CHK("pin capture", 1'b1, d >= c0 && d <= c1)
		end
		rd(REG_CONTROL, d, r);
		`CHK("pin flags", 3'b011, d[6:4])
		`CHK("capture irq", 1'b1, timer_irq)
		repeat (400) @(posedge aclk);
		rdcnt(c0);
		radio_event <= 8'h01;
		repeat (2) @(posedge aclk);
		radio_event <= 8'h00;
		repeat (20) @(posedge aclk);
		rdcnt(c1);
		rd(REG_CAPT0 + 8'h08, d, r);
		`CHK("radio capture", 1'b1, d >= c0 && d <= c1)
		rd(REG_CONTROL, d, r);
		`CHK("all flags", 3'b111, d[6:4])
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(REG_CONTROL, d, r);
		`CHK("flags after reset", 32'h0, d)
		rdcnt(c0);
		`CHK("count after reset", 32'h0, c0)
		rd(REG_CAPT0, d, r);
		`CHK("capture after reset", 32'h0, d)
		print_verdict();
	end
endmodule
